// File: rtl/port_e_gpio.sv
// Port E GPIO with parallel-slave status, AXI4-Lite register slave
//
// Behaviour
// - Four pins: three bidirectional, one input
// - Analog-configured pins read as zero
// - Direction 1 tristates, 0 drives latch
// - Direction bits govern drivers even when analog
// - Reset leaves pins zero to two analog
// - Latch reads return latch, not pins
// - Outputs ignore analog; analog kills input path
// - Pin three input; master clear when configured
// - Small package: only pin three, if clear off
// - Unimplemented register bits read zero
// - Direction register bit three reads zero
// - Input-full is read-only receive status
// - Output-full is read-only transmit status
// - Overflow sets on write while full
// - Mode bit selects slave or GPIO
// - Slave mode: pins become read, write, select
// - Slave needs no multi-PWM, digital config
// - Host write ends: set input-full, interrupt flag
// - Host read: drive data, clear output-full (the code drives no data; the pins stay released)
//
// Local design decisions: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps

module port_e_gpio
    import port_e_pkg::*;
#(
    parameter bit LARGE_PACKAGE = 1'b1
)(
    // Clock, reset, enable
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire logic                    clk_en,
    // AXI4-Lite write address
    input  wire logic [3:0]              s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [3:0]              s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    // Port pins
    input  wire logic [2:0]              pin_in,
    output pin_drive_s                   pin_drive,
    input  wire logic                    port_pin3_input_only,
    // Configuration and neighbours
    input  wire logic                    master_clear_enable_cfg,
    output logic                         master_clear_input,
    output logic                         host_write_done,
    output logic                         host_read_active,
    output logic                         slave_port_active
);

    // -------------------------------------------------------------------
    // Pin synchronisers
    // -------------------------------------------------------------------
    logic [3:0] sync_a;
    logic [3:0] sync_b;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync_a <= 4'hF;
            sync_b <= 4'hF;
        end
        else if (clk_en)
        begin
            sync_a <= {port_pin3_input_only, pin_in};
            sync_b <= sync_a;
        end
    end

    // -------------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------------
    logic [2:0] output_latch;
    logic [2:0] direction;
    logic       slave_port_mode_select;
    logic       input_buffer_full;
    logic       output_buffer_full;
    logic       input_buffer_overflow;
    logic       slave_port_interrupt_flag;
    logic [3:0] analog_pin_config_field;
    logic       pwm_multi_output;

    logic [3:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic       have_aw;
    logic       have_w;
    logic       do_write;
    logic       do_read;

    // -------------------------------------------------------------------
    // Pin roles
    // -------------------------------------------------------------------
    logic       pins_digital;
    logic       slave_on;
    logic       rd_n;
    logic       wr_n;
    logic       cs_n;
    logic       write_active;
    logic       read_active;
    logic [3:0] pin_read;

    assign pins_digital = analog_pin_config_field >= ANALOG_DIGITAL_MIN;
    assign slave_on = LARGE_PACKAGE && slave_port_mode_select
                      && !pwm_multi_output && pins_digital
                      && (direction == 3'b111);
    assign rd_n = sync_b[0];
    assign wr_n = sync_b[1];
    assign cs_n = sync_b[2];
    assign slave_port_active = slave_on;

    // Analog pins read zero; small package lacks pins 0..2
    assign pin_read[2:0] = (LARGE_PACKAGE && pins_digital)
                           ? sync_b[2:0] : 3'b000;
    // Pin three reads only when master clear is off
    assign pin_read[3] = master_clear_enable_cfg ? 1'b0
                         : sync_b[3];
    assign master_clear_input = master_clear_enable_cfg
                                & ~sync_b[3];

    // Drivers follow direction bits whatever the analog setting
    always_comb
    begin
        pin_drive.out  = output_latch;
        pin_drive.oe_n = LARGE_PACKAGE ? direction : 3'b111;
    end

    // -------------------------------------------------------------------
    // Host strobe tracking
    // -------------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            write_active <= 1'b0;
            read_active  <= 1'b0;
        end
        else if (clk_en)
        begin
            write_active <= slave_on && !cs_n && !wr_n;
            read_active  <= slave_on && !cs_n && !rd_n;
        end
    end

    logic write_end;
    logic read_start;
    logic read_end;
    assign write_end  = write_active && !(slave_on && !cs_n && !wr_n);
    assign read_start = !read_active && slave_on && !cs_n && !rd_n;
    assign read_end   = read_active && !(slave_on && !cs_n && !rd_n);
    assign host_write_done  = write_end & clk_en;
    assign host_read_active = read_active;

    // -------------------------------------------------------------------
    // AXI4-Lite write channel
    // -------------------------------------------------------------------
    // No handshake while frozen, or the item would be lost
    assign s_axi_awready = clk_en && !have_aw && !s_axi_bvalid;
    assign s_axi_wready  = clk_en && !have_w && !s_axi_bvalid;
    assign do_write = have_aw && have_w && !s_axi_bvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            have_aw      <= 1'b0;
            have_w       <= 1'b0;
            wr_addr      <= 4'h0;
            wr_data      <= 32'h0000_0000;
            wr_strb      <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end
        else if (clk_en)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                have_aw <= 1'b1;
                wr_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                have_w  <= 1'b1;
                wr_data <= s_axi_wdata;
                wr_strb <= s_axi_wstrb;
            end
            if (do_write)
            begin
                have_aw      <= 1'b0;
                have_w       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wr_addr[1:0] == 2'b00) ? RESP_OKAY
                                : RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    logic wr_lane0;
    assign wr_lane0 = do_write && wr_strb[0];

    // -------------------------------------------------------------------
    // Software-owned bits
    // -------------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            output_latch           <= RST_LATCH;
            direction              <= RST_DIR_STATUS[2:0];
            slave_port_mode_select <= RST_DIR_STATUS[BIT_SLAVE_MODE];
            analog_pin_config_field <= RST_ANALOG_CFG;
            pwm_multi_output       <= 1'b0;
        end
        else if (clk_en && wr_lane0)
        begin
            // Writes to the pin-level address land in the latch
            if (wr_addr == OFS_PIN_LEVELS || wr_addr == OFS_OUTPUT_LATCH)
                output_latch <= wr_data[2:0];
            if (wr_addr == OFS_DIR_STATUS)
            begin
                direction              <= wr_data[2:0];
                slave_port_mode_select <= wr_data[BIT_SLAVE_MODE];
            end
            if (wr_addr == OFS_SLAVE_CONTROL)
            begin
                analog_pin_config_field <= wr_data[3:0];
                pwm_multi_output <= wr_data[BIT_PWM_MULTI];
            end
        end
    end

    // -------------------------------------------------------------------
    // Hardware status flags (hardware event wins over software write)
    // -------------------------------------------------------------------
    logic clr_overflow;
    logic clr_irq;
    logic sw_load_output;
    logic sw_read_input;
    assign clr_overflow = wr_lane0 && wr_addr == OFS_DIR_STATUS
                          && !wr_data[BIT_OVERFLOW];
    assign clr_irq = wr_lane0 && wr_addr == OFS_SLAVE_CONTROL
                     && !wr_data[BIT_IRQ_FLAG];
    // CPU side of the data buffers, exposed through the control register
    assign sw_load_output = wr_lane0 && wr_addr == OFS_SLAVE_CONTROL
                            && wr_data[BIT_OUTPUT_FULL];
    assign sw_read_input  = wr_lane0 && wr_addr == OFS_SLAVE_CONTROL
                            && wr_data[BIT_INPUT_FULL];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            input_buffer_full        <= 1'b0;
            output_buffer_full       <= 1'b0;
            input_buffer_overflow    <= 1'b0;
            slave_port_interrupt_flag <= 1'b0;
        end
        else if (clk_en)
        begin
            if (write_end)
                input_buffer_full <= 1'b1;
            else if (sw_read_input)
                input_buffer_full <= 1'b0;
            // A read in progress drains a new word at once
            if (read_start || read_active)
                output_buffer_full <= 1'b0;
            else if (sw_load_output)
                output_buffer_full <= 1'b1;
            if (write_end && input_buffer_full)
                input_buffer_overflow <= 1'b1;
            else if (clr_overflow)
                input_buffer_overflow <= 1'b0;
            if (write_end || read_end)
                slave_port_interrupt_flag <= 1'b1;
            else if (clr_irq)
                slave_port_interrupt_flag <= 1'b0;
        end
    end

    // -------------------------------------------------------------------
    // AXI4-Lite read channel
    // -------------------------------------------------------------------
    logic [7:0] rd_word;
    assign s_axi_arready = clk_en && !s_axi_rvalid;
    assign do_read = s_axi_arvalid && s_axi_arready;

    always_comb
    begin
        rd_word = 8'h00;
        unique case (s_axi_araddr)
            OFS_PIN_LEVELS:    rd_word = {4'h0, pin_read};
            OFS_OUTPUT_LATCH:  rd_word = {5'h00, output_latch};
            OFS_DIR_STATUS:    rd_word = {input_buffer_full,
                                          output_buffer_full,
                                          input_buffer_overflow,
                                          slave_port_mode_select,
                                          1'b0, direction};
            OFS_SLAVE_CONTROL: rd_word = {2'b00,
                                          slave_port_interrupt_flag,
                                          pwm_multi_output,
                                          analog_pin_config_field};
            default:           rd_word = 8'h00;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end
        else if (clk_en)
        begin
            if (do_read)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h00_0000, rd_word};
                s_axi_rresp  <= (s_axi_araddr[1:0] == 2'b00) ? RESP_OKAY
                                : RESP_SLVERR;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

endmodule : port_e_gpio

// File: rtl/port_e_pkg.sv
// Port E register map, field layout and reset values
package port_e_pkg;

    // -------------------------------------------------------------------
    // Register offsets (byte addresses)
    // -------------------------------------------------------------------
    localparam logic [3:0] OFS_PIN_LEVELS    = 4'h0;
    localparam logic [3:0] OFS_OUTPUT_LATCH  = 4'h4;
    localparam logic [3:0] OFS_DIR_STATUS    = 4'h8;
    localparam logic [3:0] OFS_SLAVE_CONTROL = 4'hC;

    // -------------------------------------------------------------------
    // Direction/status field positions
    // -------------------------------------------------------------------
    localparam int BIT_INPUT_FULL  = 7;
    localparam int BIT_OUTPUT_FULL = 6;
    localparam int BIT_OVERFLOW    = 5;
    localparam int BIT_SLAVE_MODE  = 4;

    // -------------------------------------------------------------------
    // Slave-control register fields
    // -------------------------------------------------------------------
    localparam int BIT_PWM_MULTI    = 4;
    localparam int BIT_IRQ_FLAG     = 5;

    // -------------------------------------------------------------------
    // Reset values and the digital threshold
    // -------------------------------------------------------------------
    localparam logic [7:0] RST_DIR_STATUS   = 8'h07;
    localparam logic [2:0] RST_LATCH        = 3'h0;
    localparam logic [3:0] RST_ANALOG_CFG   = 4'h0;
    localparam logic [3:0] ANALOG_DIGITAL_MIN = 4'hA;

    // -------------------------------------------------------------------
    // AXI responses
    // -------------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Pins of the three configurable lines, as one group
    typedef struct packed {
        logic [2:0] out;
        logic [2:0] oe_n;
    } pin_drive_s;

endpackage : port_e_pkg

// File: sim/port_e_gpio_props.sv
// Concurrent checks on the port E register slave and pins
`timescale 1ns/1ps

module port_e_gpio_props
    import port_e_pkg::*;
#(
    parameter bit LARGE_PACKAGE = 1'b1
)(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        clk_en,
    // Register bus
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // Pins and status
    input  wire logic [2:0]  pin_in,
    input  wire pin_drive_s  pin_drive,
    input  wire logic        master_clear_enable_cfg,
    input  wire logic        master_clear_input,
    input  wire logic        host_write_done,
    input  wire logic        host_read_active,
    input  wire logic        slave_port_active
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Address of the read under way, to judge its data
    logic [3:0] rd_addr;
    always_ff @(posedge aclk)
        if (s_axi_arvalid && s_axi_arready && clk_en)
            rd_addr <= s_axi_araddr;

    sequence s_ar_taken; s_axi_arvalid && s_axi_arready && clk_en; endsequence
    sequence s_r_held; s_axi_rvalid && !s_axi_rready && clk_en; endsequence

    property p_rst_dir;
        $rose(aresetn) |-> pin_drive.oe_n == 3'b111;
    endproperty
    property p_read_answer; s_ar_taken |=> s_axi_rvalid; endproperty
    property p_read_stands;
        s_r_held |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_write_stands;
        s_axi_bvalid && !s_axi_bready && clk_en |=> s_axi_bvalid;
    endproperty
    property p_upper_zero; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000;
    endproperty
    property p_dir_bit3;
        s_axi_rvalid && rd_addr == OFS_DIR_STATUS |-> !s_axi_rdata[3];
    endproperty
    property p_latch_bits;
        s_axi_rvalid && rd_addr == OFS_OUTPUT_LATCH
            |-> s_axi_rdata[7:3] == 5'h0;
    endproperty
    property p_slave_released;
        slave_port_active |-> LARGE_PACKAGE && pin_drive.oe_n == 3'b111;
    endproperty
    property p_write_end;
        host_write_done |-> slave_port_active && (pin_in[1] || pin_in[2]);
    endproperty
    property p_read_start;
        $rose(host_read_active) |-> !pin_in[0] && !pin_in[2];
    endproperty
    property p_clear_cfg; master_clear_input |-> master_clear_enable_cfg;
    endproperty

    a_rst_dir: assert property (p_rst_dir) else $error("dir not 111");
    a_read_answer: assert property (p_read_answer) else $error("no rvalid");
    a_read_stands: assert property (p_read_stands) else $error("r dropped");
    a_write_stands: assert property (p_write_stands) else $error("b dropped");
    a_upper_zero: assert property (p_upper_zero) else $error("upper");
    a_dir_bit3: assert property (p_dir_bit3) else $error("bit3 set");
    a_latch_bits: assert property (p_latch_bits) else $error("latch");
    a_slave_released: assert property (p_slave_released)
        else $error("slave pins driven");
    a_write_end: assert property (p_write_end) else $error("bad end");
    a_read_start: assert property (p_read_start) else $error("bad rd");
    a_clear_cfg: assert property (p_clear_cfg) else $error("bad clear");
endmodule : port_e_gpio_props

bind port_e_gpio port_e_gpio_props #(.LARGE_PACKAGE(LARGE_PACKAGE)) props_u (
    .aclk, .aresetn, .clk_en, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .s_axi_bready,
    .pin_in, .pin_drive, .master_clear_enable_cfg, .master_clear_input,
    .host_write_done, .host_read_active, .slave_port_active
);

// File: sim/port_e_host_model.sv
// External host driving the three strobe pins
`timescale 1ns/1ps

module port_e_host_model
    import port_e_pkg::*;
(
    // Clock
    input  wire logic       aclk,
    // Port side
    input  wire pin_drive_s pin_drive,
    output logic [2:0]      pin_in
);
    // Strobes idle high: read, write, select
    logic [2:0] strobe_n = 3'b111;

    // A driving port wins; host shows only on released pins
    always_comb
        for (int i = 0; i < 3; i++)
            pin_in[i] = pin_drive.oe_n[i] ? strobe_n[i] : pin_drive.out[i];

    task automatic host_cycle(input logic is_write);
        @(posedge aclk);
        strobe_n <= is_write ? 3'b001 : 3'b010;
        repeat (6) @(posedge aclk);
        strobe_n <= 3'b111;
        repeat (6) @(posedge aclk);
    endtask : host_cycle
endmodule : port_e_host_model

// File: sim/port_e_gpio_bench.sv
// Self-checking bench for the port E register slave
`timescale 1ns/1ps

module port_e_gpio_bench;
    import port_e_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [2:0] pin_in;
    pin_drive_s pin_drive;
    logic port_pin3_input_only = 1'b1, master_clear_enable_cfg = 1'b0;
    logic master_clear_input, host_write_done, host_read_active;
    logic slave_port_active;
    logic [31:0] got;
    logic [7:0] cfg_tab [4] = '{8'h1A, 8'h09, 8'h0F, 8'h0A};
    logic [3:0] act_tab = 4'b1100;
    int n_errors = 0, tests_run = 0, cycles = 0;

    always #12.5 aclk = ~aclk;

    port_e_gpio dut_u (.aclk, .aresetn, .clk_en, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .pin_in, .pin_drive, .port_pin3_input_only, .master_clear_enable_cfg,
        .master_clear_input, .host_write_done, .host_read_active,
        .slave_port_active);
    port_e_host_model host_u (.aclk, .pin_drive, .pin_in);

    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    task automatic axi_write(input logic [3:0] a, input logic [7:0] d);
        logic ah, wh, bh;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(negedge aclk);
            ah = s_axi_awvalid & s_axi_awready;
            wh = s_axi_wvalid & s_axi_wready;
            bh = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge aclk);
            if (ah) s_axi_awvalid <= 1'b0;
            if (wh) s_axi_wvalid <= 1'b0;
        end
        while (!bh);
        s_axi_bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [3:0] a);
        logic ah, rh;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(negedge aclk);
            ah = s_axi_arvalid & s_axi_arready;
            rh = s_axi_rvalid;
            got = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge aclk);
            if (ah) s_axi_arvalid <= 1'b0;
        end
        while (!rh);
        s_axi_rready <= 1'b0;
    endtask : axi_read

    task automatic check(input logic [31:0] got_v, input logic [31:0] exp_v);
        tests_run++;
        if (got_v !== exp_v)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h",
                     $time, got_v, exp_v);
        end
    endtask : check

    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
        axi_read(a);
        check(got, {24'h00_0000, e});
        check({30'h0, resp}, {30'h0, RESP_OKAY});
    endtask : rd_chk

    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop

    // A hang counts as a mismatch
    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_errors++;
            report_and_stop();
        end
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial
    begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        rd_chk(OFS_DIR_STATUS, 8'h07);
        rd_chk(OFS_OUTPUT_LATCH, 8'h00);
        rd_chk(OFS_PIN_LEVELS, 8'h08);
        $display("reset test done");
        axi_write(OFS_OUTPUT_LATCH, 8'hFD);
        check({30'h0, resp}, {30'h0, RESP_OKAY});
        rd_chk(OFS_OUTPUT_LATCH, 8'h05);
        axi_write(OFS_DIR_STATUS, 8'h0A);
        rd_chk(OFS_DIR_STATUS, 8'h02);
        check({26'h0, pin_drive}, 32'h0000_002A);
        rd_chk(OFS_PIN_LEVELS, 8'h08);
        axi_write(OFS_SLAVE_CONTROL, 8'h0A);
        check({26'h0, pin_drive}, 32'h0000_002A);
        rd_chk(OFS_PIN_LEVELS, 8'h0F);
        axi_write(4'h5, 8'h00);
        check({30'h0, resp}, {30'h0, RESP_SLVERR});
        axi_read(4'h6);
        check({30'h0, resp}, {30'h0, RESP_SLVERR});
        rd_chk(OFS_OUTPUT_LATCH, 8'h05);
        $display("gpio test done");
        axi_write(OFS_DIR_STATUS, 8'h17);
        rd_chk(OFS_DIR_STATUS, 8'h17);
        foreach (cfg_tab[i])
        begin
            axi_write(OFS_SLAVE_CONTROL, cfg_tab[i]);
            repeat (2) @(negedge aclk);
            check({31'h0, slave_port_active}, {31'h0, act_tab[i]});
        end
        host_u.host_cycle(1'b1);
        host_u.host_cycle(1'b1);
        rd_chk(OFS_DIR_STATUS, 8'hB7);
        rd_chk(OFS_SLAVE_CONTROL, 8'h2A);
        axi_write(OFS_SLAVE_CONTROL, 8'hCA);
        axi_write(OFS_DIR_STATUS, 8'hD7);
        rd_chk(OFS_DIR_STATUS, 8'h57);
        rd_chk(OFS_SLAVE_CONTROL, 8'h0A);
        host_u.host_cycle(1'b0);
        rd_chk(OFS_DIR_STATUS, 8'h17);
        rd_chk(OFS_SLAVE_CONTROL, 8'h2A);
        $display("slave test done");
        rd_chk(OFS_PIN_LEVELS, 8'h0F);
        clk_en <= 1'b0;
        master_clear_enable_cfg <= 1'b1;
        port_pin3_input_only <= 1'b0;
        repeat (4) @(negedge aclk);
        check({31'h0, master_clear_input}, 32'h0000_0000);
        @(posedge aclk);
        clk_en <= 1'b1;
        repeat (4) @(negedge aclk);
        check({31'h0, master_clear_input}, 32'h0000_0001);
        port_pin3_input_only <= 1'b1;
        rd_chk(OFS_PIN_LEVELS, 8'h07);
        $display("clear test done");
        report_and_stop();
    end
endmodule : port_e_gpio_bench
